/* common/bsf_pkg.sv */
// package: constants, opcodes and state for the bit, shift and flag unit
`default_nettype none
package bsf_pkg;
  // status register bit positions
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam int FLAG_T = 6;
  localparam int FLAG_I = 7;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;
  // cycle counts
  localparam int POP_CYCLES = 2;
  localparam int ONE_CYCLE = 1;
  // wishbone register offsets (byte addresses)
  localparam logic [3:0] ADDR_STATUS = 4'h0;
  localparam logic [3:0] ADDR_RESULT = 4'h4;
  localparam logic [3:0] ADDR_EVENTS = 4'h8;
  typedef enum logic [4:0] {
    OP_NOP = 5'b00000,
    OP_POP = 5'b00001,
    OP_IO_BIT_SET = 5'b00010,
    OP_IO_BIT_CLEAR = 5'b00011,
    OP_SHIFT_LEFT_LOGICAL = 5'b00100,
    OP_SHIFT_RIGHT_LOGICAL = 5'b00101,
    OP_ROTATE_LEFT_THRU_CARRY = 5'b00110,
    OP_ROTATE_RIGHT_THRU_CARRY = 5'b00111,
    OP_SHIFT_RIGHT_ARITH = 5'b01000,
    OP_NIBBLE_EXCHANGE = 5'b01001,
    OP_STATUS_FLAG_SET = 5'b01010,
    OP_STATUS_FLAG_CLEAR = 5'b01011,
    OP_STORE_BIT_TO_TRANSFER_FLAG = 5'b01100,
    OP_LOAD_BIT_FROM_TRANSFER_FLAG = 5'b01101,
    OP_SLEEP = 5'b01110,
    OP_WATCHDOG_RESTART = 5'b01111,
    OP_BREAK = 5'b10000
  } op_t;
  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_POP2 = 1'b1
  } state_t;
endpackage
`default_nettype wire

/* logic/bit_shift_flag_unit.sv */
// bit manipulation, shift, flag and mcu control execution unit
`default_nettype none
module bit_shift_flag_unit (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // instruction issue from the decoder
  input wire logic issue_i,
  input wire logic [4:0] op_i,
  input wire logic [2:0] bit_sel_i,
  input wire logic [7:0] operand_i,
  input wire logic [7:0] stack_data_i,
  // results back to the register file and i/o space
  output logic busy_o,
  output logic wr_en_o,
  output logic [7:0] wr_data_o,
  output logic io_wr_en_o,
  output logic [7:0] io_wr_data_o,
  output logic [7:0] status_o,
  // mcu control events
  output logic sleep_o,
  output logic watchdog_restart_o,
  output logic break_o,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    bsf_pkg::state_t state;
    logic [7:0] status;
    logic wr_en;
    logic [7:0] wr_data;
    logic io_wr_en;
    logic [7:0] io_wr_data;
    logic sleep;
    logic watchdog_restart_op;
    logic brk;
    logic [7:0] last_result;
    logic [7:0] sleep_cnt;
    logic [7:0] wdr_cnt;
    logic [7:0] brk_cnt;
    logic ack;
    logic err;
    logic [31:0] dat;
  } unit_state_t;

  unit_state_t cur_reg;
  unit_state_t cur_next;

  logic [7:0] sh_result;
  logic sh_carry;
  logic sh_zero;
  logic sh_neg;
  logic sh_ovf;
  logic sh_upd;

  shift_core u_shift_core (
    .op_i(op_i),
    .data_i(operand_i),
    .carry_i(cur_reg.status[bsf_pkg::FLAG_C]),
    .result_o(sh_result),
    .carry_o(sh_carry),
    .zero_o(sh_zero),
    .neg_o(sh_neg),
    .ovf_o(sh_ovf),
    .flags_upd_o(sh_upd)
  );

  // ----------------------------------------
  // instruction decode
  // ----------------------------------------
  logic take;
  logic dec_pop;
  logic dec_io_set;
  logic dec_io_clr;
  logic dec_shift;
  logic dec_flag_set;
  logic dec_flag_clr;
  logic dec_t_store;
  logic dec_t_load;
  logic dec_sleep;
  logic dec_wdr;
  logic dec_brk;
  logic [7:0] bit_mask;

  // an issue in the second pop cycle is dropped, the decoder must hold off
  assign take = issue_i && (cur_reg.state == bsf_pkg::ST_IDLE);
  assign bit_mask = 8'h01 << bit_sel_i;

  always_comb begin
    dec_pop = 1'b0;
    dec_io_set = 1'b0;
    dec_io_clr = 1'b0;
    dec_shift = 1'b0;
    dec_flag_set = 1'b0;
    dec_flag_clr = 1'b0;
    dec_t_store = 1'b0;
    dec_t_load = 1'b0;
    dec_sleep = 1'b0;
    dec_wdr = 1'b0;
    dec_brk = 1'b0;
    if (take) begin
      case (bsf_pkg::op_t'(op_i))
        bsf_pkg::OP_POP: begin
          dec_pop = 1'b1;
        end
        bsf_pkg::OP_IO_BIT_SET: begin
          dec_io_set = 1'b1;
        end
        bsf_pkg::OP_IO_BIT_CLEAR: begin
          dec_io_clr = 1'b1;
        end
        bsf_pkg::OP_SHIFT_LEFT_LOGICAL: begin
          dec_shift = 1'b1;
        end
        bsf_pkg::OP_SHIFT_RIGHT_LOGICAL: begin
          dec_shift = 1'b1;
        end
        bsf_pkg::OP_ROTATE_LEFT_THRU_CARRY: begin
          dec_shift = 1'b1;
        end
        bsf_pkg::OP_ROTATE_RIGHT_THRU_CARRY: begin
          dec_shift = 1'b1;
        end
        bsf_pkg::OP_SHIFT_RIGHT_ARITH: begin
          dec_shift = 1'b1;
        end
        bsf_pkg::OP_NIBBLE_EXCHANGE: begin
          dec_shift = 1'b1;
        end
        bsf_pkg::OP_STATUS_FLAG_SET: begin
          dec_flag_set = 1'b1;
        end
        bsf_pkg::OP_STATUS_FLAG_CLEAR: begin
          dec_flag_clr = 1'b1;
        end
        bsf_pkg::OP_STORE_BIT_TO_TRANSFER_FLAG: begin
          dec_t_store = 1'b1;
        end
        bsf_pkg::OP_LOAD_BIT_FROM_TRANSFER_FLAG: begin
          dec_t_load = 1'b1;
        end
        bsf_pkg::OP_SLEEP: begin
          dec_sleep = 1'b1;
        end
        bsf_pkg::OP_WATCHDOG_RESTART: begin
          dec_wdr = 1'b1;
        end
        bsf_pkg::OP_BREAK: begin
          dec_brk = 1'b1;
        end
        default: begin
          // nop and unused codes leave every output and flag alone
          dec_pop = 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------
  // status register
  // ----------------------------------------
  logic [7:0] status_op;
  logic [7:0] status_bus;
  logic bus_take;
  logic bus_hit;
  logic hit_status;
  logic hit_result;
  logic hit_events;
  logic [31:0] bus_rd_data;

  always_comb begin
    status_op = cur_reg.status;
    if (dec_shift && sh_upd) begin
      status_op[bsf_pkg::FLAG_Z] = sh_zero;
      status_op[bsf_pkg::FLAG_C] = sh_carry;
      status_op[bsf_pkg::FLAG_N] = sh_neg;
      status_op[bsf_pkg::FLAG_V] = sh_ovf;
    end
    if (dec_flag_set) begin
      // dedicated flag ops reach here as an index set by the decoder
      status_op = cur_reg.status | bit_mask;
    end
    if (dec_flag_clr) begin
      status_op = cur_reg.status & ~bit_mask;
    end
    if (dec_t_store) begin
      status_op[bsf_pkg::FLAG_T] = operand_i[bit_sel_i];
    end
  end

  // ----------------------------------------
  // register bus decode
  // ----------------------------------------
  assign bus_take = wb_cyc_i && wb_stb_i && !cur_reg.ack && !cur_reg.err;
  assign bus_hit = hit_status || hit_result || hit_events;

  always_comb begin
    hit_status = 1'b0;
    hit_result = 1'b0;
    hit_events = 1'b0;
    bus_rd_data = 32'h0000_0000;
    if (wb_adr_i == bsf_pkg::ADDR_STATUS) begin
      hit_status = 1'b1;
      bus_rd_data = {24'h00_0000, cur_reg.status};
    end else if (wb_adr_i == bsf_pkg::ADDR_RESULT) begin
      hit_result = 1'b1;
      bus_rd_data = {24'h00_0000, cur_reg.last_result};
    end else if (wb_adr_i == bsf_pkg::ADDR_EVENTS) begin
      hit_events = 1'b1;
      bus_rd_data = {8'h00, cur_reg.brk_cnt, cur_reg.wdr_cnt, cur_reg.sleep_cnt};
    end
  end

  // software write wins over a same-cycle instruction update; lanes 3..1 are unused
  always_comb begin
    status_bus = status_op;
    if (bus_take && hit_status && wb_we_i && wb_sel_i[0]) begin
      status_bus = wb_dat_i[7:0];
    end
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    cur_next = cur_reg;
    cur_next.status = status_bus;
    cur_next.wr_en = 1'b0;
    cur_next.io_wr_en = 1'b0;
    cur_next.sleep = 1'b0;
    cur_next.watchdog_restart_op = 1'b0;
    cur_next.brk = 1'b0;
    cur_next.ack = 1'b0;
    cur_next.err = 1'b0;
    case (cur_reg.state)
      bsf_pkg::ST_POP2: begin
        // second cycle of pop: register written, flags untouched
        cur_next.wr_en = 1'b1;
        cur_next.wr_data = stack_data_i;
        cur_next.last_result = stack_data_i;
        cur_next.state = bsf_pkg::ST_IDLE;
      end
      default: begin
        if (dec_pop) begin
          cur_next.state = bsf_pkg::ST_POP2;
        end
      end
    endcase
    if (dec_io_set) begin
      cur_next.io_wr_en = 1'b1;
      cur_next.io_wr_data = operand_i | bit_mask;
    end
    if (dec_io_clr) begin
      cur_next.io_wr_en = 1'b1;
      cur_next.io_wr_data = operand_i & ~bit_mask;
    end
    if (dec_shift) begin
      cur_next.wr_en = 1'b1;
      cur_next.wr_data = sh_result;
      cur_next.last_result = sh_result;
    end
    if (dec_t_load) begin
      cur_next.wr_en = 1'b1;
      cur_next.wr_data = operand_i;
      cur_next.wr_data[bit_sel_i] = cur_reg.status[bsf_pkg::FLAG_T];
      cur_next.last_result = cur_next.wr_data;
    end
    // event counters wrap at 8 bits; software sees them as a running tally
    if (dec_sleep) begin
      cur_next.sleep = 1'b1;
      cur_next.sleep_cnt = cur_reg.sleep_cnt + 8'h01;
    end
    if (dec_wdr) begin
      cur_next.watchdog_restart_op = 1'b1;
      cur_next.wdr_cnt = cur_reg.wdr_cnt + 8'h01;
    end
    if (dec_brk) begin
      cur_next.brk = 1'b1;
      cur_next.brk_cnt = cur_reg.brk_cnt + 8'h01;
    end
    if (bus_take) begin
      cur_next.ack = bus_hit;
      cur_next.err = !bus_hit;
      cur_next.dat = bus_rd_data;
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cur_reg <= '0;
      cur_reg.status <= bsf_pkg::STATUS_RESET;
      cur_reg.state <= bsf_pkg::ST_IDLE;
    end else if (ce_i) begin
      cur_reg <= cur_next;
    end
  end

  assign busy_o = (cur_reg.state == bsf_pkg::ST_POP2);
  assign wr_en_o = cur_reg.wr_en;
  assign wr_data_o = cur_reg.wr_data;
  assign io_wr_en_o = cur_reg.io_wr_en;
  assign io_wr_data_o = cur_reg.io_wr_data;
  assign status_o = cur_reg.status;
  assign sleep_o = cur_reg.sleep;
  assign watchdog_restart_o = cur_reg.watchdog_restart_op;
  assign break_o = cur_reg.brk;
  assign wb_dat_o = cur_reg.dat;
  assign wb_ack_o = cur_reg.ack;
  assign wb_err_o = cur_reg.err;
endmodule
`default_nettype wire

/* logic/shift_core.sv */
// combinational shift, rotate and swap datapath with its flag results
`default_nettype none
module shift_core (
  // operation and operands
  input wire logic [4:0] op_i,
  input wire logic [7:0] data_i,
  input wire logic carry_i,
  // result
  output logic [7:0] result_o,
  output logic carry_o,
  output logic zero_o,
  output logic neg_o,
  output logic ovf_o,
  output logic flags_upd_o
);
  always_comb begin
    result_o = data_i;
    carry_o = carry_i;
    flags_upd_o = 1'b0;
    case (op_i)
      bsf_pkg::OP_SHIFT_LEFT_LOGICAL: begin
        result_o = {data_i[6:0], 1'b0};
        carry_o = data_i[7];
        flags_upd_o = 1'b1;
      end
      bsf_pkg::OP_SHIFT_RIGHT_LOGICAL: begin
        result_o = {1'b0, data_i[7:1]};
        carry_o = data_i[0];
        flags_upd_o = 1'b1;
      end
      bsf_pkg::OP_ROTATE_LEFT_THRU_CARRY: begin
        result_o = {data_i[6:0], carry_i};
        carry_o = data_i[7];
        flags_upd_o = 1'b1;
      end
      bsf_pkg::OP_ROTATE_RIGHT_THRU_CARRY: begin
        result_o = {carry_i, data_i[7:1]};
        carry_o = data_i[0];
        flags_upd_o = 1'b1;
      end
      bsf_pkg::OP_SHIFT_RIGHT_ARITH: begin
        result_o = {data_i[7], data_i[7:1]};
        carry_o = data_i[0];
        flags_upd_o = 1'b1;
      end
      bsf_pkg::OP_NIBBLE_EXCHANGE: begin
        result_o = {data_i[3:0], data_i[7:4]};
      end
      default: begin
        result_o = data_i;
      end
    endcase
  end
  assign zero_o = (result_o == 8'h00);
  assign neg_o = result_o[7];
  // overflow taken as negative xor carry, the usual two's complement reading of a shift
  assign ovf_o = result_o[7] ^ carry_o;
endmodule
`default_nettype wire

/* tb/bit_shift_flag_unit_tb_top.sv */
// testbench: flag, shift, bit, pop, event and bus checks for the unit
`default_nettype none
module bit_shift_flag_unit_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 0, rst_i = 1, ce_i = 1, issue_i = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  logic busy_o, wr_en_o, io_wr_en_o, sleep_o, watchdog_restart_o, break_o, wb_ack_o, wb_err_o;
  logic [4:0] op_i = 5'h00, op;
  logic [2:0] bit_sel_i = 3'h0, b;
  logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'h0;
  logic [7:0] operand_i = 8'h00, top = 8'h00, st = 8'h00, stack_data_i, wr_data_o, d, e;
  logic [7:0] io_wr_data_o, status_o;
  logic [8:0] res;
  logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o, q;
  logic er, c;
  logic [7:0] exp_q[$];
  int error_cnt = 0, checked = 0, cyc = 0;
  bit_shift_flag_unit u_dut (.*);
  stack_model u_stack (.clk_i(clk_i), .busy_i(busy_o), .top_i(top), .data_o(stack_data_i));
  always #12.5 clk_i = ~clk_i;
  task automatic close_out;
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      close_out;
    end
  end
  task automatic cmp(input logic [31:0] ex, input logic [31:0] got);
    checked++;
    if (got !== ex) begin
      error_cnt++;
      $display("BAD t=%0t exp=%h got=%h", $time, ex, got);
    end
  endtask
  // ----------------------------------------
  // watcher: every register or i/o write is matched to the oldest note
  // ----------------------------------------
  always @(negedge clk_i) begin
    if (wr_en_o === 1'b1 || io_wr_en_o === 1'b1)
      cmp(exp_q.size() ? exp_q.pop_front() : 8'hxx, wr_en_o ? wr_data_o : io_wr_data_o);
  end
  task automatic exec(input logic [4:0] o, input logic [2:0] bs, input logic [7:0] dv);
    @(posedge clk_i);
    issue_i <= 1'b1;
    op_i <= o;
    bit_sel_i <= bs;
    operand_i <= dv;
    @(posedge clk_i);
    issue_i <= 1'b0;
    @(negedge clk_i);
  endtask
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] dv);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_sel_i <= 4'h1;
    wb_dat_i <= dv;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1);
    q = wb_dat_o;
    er = wb_err_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  initial begin
    void'($urandom(32'hfe92));
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 16; i++) begin
      exec(i < 8 ? bsf_pkg::OP_STATUS_FLAG_SET : bsf_pkg::OP_STATUS_FLAG_CLEAR, i[2:0], 8'h00);
      st[i % 8] = (i < 8);
      cmp(st, status_o);
    end
    $display("flag test done");
    repeat (30) begin
      op = 5'(bsf_pkg::OP_SHIFT_LEFT_LOGICAL + $urandom_range(4));
      d = 8'($urandom);
      c = 1'($urandom);
      exec(c ? bsf_pkg::OP_STATUS_FLAG_SET : bsf_pkg::OP_STATUS_FLAG_CLEAR, 3'h0, 8'h00);
      st[0] = c;
      case (op)
        5'h04: res = {d, 1'b0};
        5'h05: res = {d[0], 1'b0, d[7:1]};
        5'h06: res = {d, c};
        5'h07: res = {d[0], c, d[7:1]};
        default: res = {d[0], d[7], d[7:1]};
      endcase
      exp_q.push_back(res[7:0]);
      exec(op, 3'h0, d);
      st[3:0] = {res[7] ^ res[8], res[7], res[7:0] == 8'h00, res[8]};
      cmp(st, status_o);
    end
    $display("shift test done");
    repeat (8) begin
      d = 8'($urandom);
      b = 3'($urandom);
      exp_q.push_back({d[3:0], d[7:4]});
      exec(bsf_pkg::OP_NIBBLE_EXCHANGE, b, d);
      exp_q.push_back(d | (8'h01 << b));
      exec(bsf_pkg::OP_IO_BIT_SET, b, d);
      exp_q.push_back(d & ~(8'h01 << b));
      exec(bsf_pkg::OP_IO_BIT_CLEAR, b, d);
      exec(bsf_pkg::OP_STORE_BIT_TO_TRANSFER_FLAG, b, d);
      st[6] = d[b];
      cmp(st, status_o);
      e = ~d;
      e[b] = st[6];
      exp_q.push_back(e);
      exec(bsf_pkg::OP_LOAD_BIT_FROM_TRANSFER_FLAG, b, ~d);
      top = d ^ 8'h5c;
      exp_q.push_back(top);
      exec(bsf_pkg::OP_POP, b, d);
      @(negedge clk_i);
      cmp(st, status_o);
    end
    $display("bit and pop test done");
    // a request held into the pop's second cycle is refused
    top = 8'h3c;
    exp_q.push_back(top);
    @(posedge clk_i);
    issue_i <= 1'b1;
    op_i <= bsf_pkg::OP_POP;
    @(posedge clk_i);
    op_i <= bsf_pkg::OP_STATUS_FLAG_SET;
    bit_sel_i <= 3'h5;
    @(posedge clk_i);
    issue_i <= 1'b0;
    @(negedge clk_i);
    cmp(st, status_o);
    // with the clock enable low nothing is taken
    @(posedge clk_i);
    ce_i <= 1'b0;
    exec(bsf_pkg::OP_STATUS_FLAG_SET, 3'h5, 8'h00);
    cmp(st, status_o);
    @(posedge clk_i);
    ce_i <= 1'b1;
    $display("refusal and enable test done");
    exec(bsf_pkg::OP_SLEEP, 3'h0, 8'h00);
    cmp(1'b1, sleep_o);
    exec(bsf_pkg::OP_WATCHDOG_RESTART, 3'h0, 8'h00);
    cmp(1'b1, watchdog_restart_o);
    exec(bsf_pkg::OP_BREAK, 3'h0, 8'h00);
    cmp(1'b1, break_o);
    cmp(st, status_o);
    wb(1'b1, bsf_pkg::ADDR_STATUS, 32'h0000_00a5);
    cmp(8'ha5, status_o);
    wb(1'b0, bsf_pkg::ADDR_STATUS, 32'h0000_0000);
    cmp(32'h0000_00a5, q);
    wb(1'b0, bsf_pkg::ADDR_RESULT, 32'h0000_0000);
    cmp({24'h00_0000, top}, q);
    wb(1'b0, bsf_pkg::ADDR_EVENTS, 32'h0000_0000);
    cmp(32'h0001_0101, q);
    wb(1'b0, 4'hc, 32'h0000_0000);
    cmp(1'b1, er);
    $display("event and bus test done");
    cmp(32'h0000_0000, 32'(exp_q.size()));
    close_out;
  end
endmodule
`default_nettype wire

/* tb/bsf_checker_assertions.sv */
// checker: result, flag and timing relations at the unit's ports
`default_nettype none
module bsf_checker (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic issue_i,
  input wire logic [4:0] op_i,
  input wire logic [2:0] bit_sel_i,
  input wire logic [7:0] operand_i,
  input wire logic busy_o,
  input wire logic wr_en_o,
  input wire logic [7:0] wr_data_o,
  input wire logic [7:0] status_o,
  input wire logic sleep_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic tk;
  logic [4:0] oq;
  logic [7:0] dq;
  logic [2:0] bq;
  logic cq;
  // ----------------------------------------
  // what the unit took, so answers tie to their cause
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    tk <= !rst_i && issue_i && ce_i && !busy_o;
    oq <= op_i;
    dq <= operand_i;
    bq <= bit_sel_i;
    cq <= status_o[0];
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  chk_pop_two_cycles: assert property (tk && oq == bsf_pkg::OP_POP |-> busy_o && !wr_en_o
    && $stable(status_o) ##1 wr_en_o && !busy_o && $stable(status_o)) else $error("pop timing");
  chk_shl_result: assert property (tk && oq == bsf_pkg::OP_SHIFT_LEFT_LOGICAL |->
    wr_en_o && wr_data_o == {dq[6:0], 1'b0} && status_o[0] == dq[7]) else $error("shl result");
  chk_rol_carry: assert property (tk && oq == bsf_pkg::OP_ROTATE_LEFT_THRU_CARRY |->
    wr_data_o == {dq[6:0], cq} && status_o[0] == dq[7]) else $error("rol result");
  chk_asr_sign: assert property (tk && oq == bsf_pkg::OP_SHIFT_RIGHT_ARITH |->
    wr_data_o == {dq[7], dq[7:1]} && status_o[0] == dq[0]) else $error("asr result");
  chk_swap_noflag: assert property (tk && oq == bsf_pkg::OP_NIBBLE_EXCHANGE |->
    wr_data_o == {dq[3:0], dq[7:4]} && $stable(status_o)) else $error("swap result");
  chk_zero_neg: assert property (tk && oq >= 5'h04 && oq <= 5'h08 |->
    status_o[1] == (wr_data_o == 8'h00) && status_o[2] == wr_data_o[7]) else $error("z or n");
  chk_flag_index: assert property (tk && oq == bsf_pkg::OP_STATUS_FLAG_SET |->
    status_o[bq]) else $error("flag set by index");
  chk_sleep_pulse: assert property (tk && oq == bsf_pkg::OP_SLEEP |->
    sleep_o && $stable(status_o) ##1 !sleep_o) else $error("sleep pulse");
  cov_pop: cover property (tk && oq == bsf_pkg::OP_POP);
  cov_rol: cover property (tk && oq == bsf_pkg::OP_ROTATE_LEFT_THRU_CARRY && cq);
  cov_zero: cover property (wr_en_o && wr_data_o == 8'h00);
endmodule
bind bit_shift_flag_unit bsf_checker u_chk (.*);
`default_nettype wire

/* tb/stack_model.sv */
// stack memory model: offers the popped byte only while the unit reads it
`default_nettype none
module stack_model (
  input wire logic clk_i,
  input wire logic busy_i,
  input wire logic [7:0] top_i,
  output logic [7:0] data_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] junk = 8'h00;
  // outside the read cycle the bus churns, so a late sample cannot pass by luck
  always @(posedge clk_i) junk <= junk + 8'h3b;
  assign data_o = busy_i ? top_i : ~top_i ^ junk;
endmodule
`default_nettype wire
